// >>> pkg/apcr_regs.vh
// register offsets, field positions and reset values of the analog control bank
// assumes an 8-bit register bank reached over a 32-bit apb slave
// Functional notes
// - reference dac code N gives bandgap times N over 255.
// - enable bit 7 turns the primary gate drive on.
// - enable bit 6 turns the secondary gate drive on, independently.
// - bits 5 and 4 bypass primary and secondary dead time independently.
// - unbypassed dead time is 16 ns to 256 ns in 16 ns steps.
// - enable bit 2 turns on the weak sense-input pull-up.
// - enable bit 1 steers open-loop pwm onto the primary drive.
// - enable bit 0 steers pwm to secondary only while overvoltage protection active.
// - both steering bits set: primary wins, secondary ignored.
// - steering pwm period from timer two period, duty from timer one low.
// - analog bit 7 connects the digital test mux to the debug pin.
// - three-bit test select picks seven sources; code 111 drives low.
// - digital test output has priority over analog on the debug pin.
// - analog only enabled routes analog test signals to the internal adc.
// - analog bit 3 selects lockout threshold 2.7 V clear, 5.4 V set.
// - analog bit 1 parks the error amplifier output low.
// - role bits 7-6 pick stand-alone, master, slave or semi-master.
// - semi-master bit 3 chooses reference pin or sync clock output.
// - stand-alone routes neither reference nor sync clock to pins.
// - mode bit 5 routes sense amplifier to internal resistor or sense pin.
// - reference dac has no pedestal, ground referenced, 255 steps.
`ifndef APCR_REGS_VH
`define APCR_REGS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define APCR_ADDR_REF2 4'h0
`define APCR_ADDR_PE1 4'h4
`define APCR_ADDR_ABE 4'h8
`define APCR_ADDR_MODE 4'hc

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define APCR_MASK_REF2 8'hff
`define APCR_MASK_PE1 8'hf7
`define APCR_MASK_ABE 8'hfb
`define APCR_MASK_MODE 8'he8
`define APCR_RESET_VAL 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define APCR_PE1_PRIMARY_GATE_DRIVE_ON 7
`define APCR_PE1_SECONDARY_GATE_DRIVE_ON 6
`define APCR_PE1_PSKIP 5
`define APCR_PE1_SSKIP 4
`define APCR_PE1_PULLUP 2
`define APCR_PE1_PSTEER 1
`define APCR_PE1_SSTEER 0
`define APCR_ABE_DIG_ON 7
`define APCR_ABE_DIGITAL_TEST_SELECT_HI 6
`define APCR_ABE_DIGITAL_TEST_SELECT_LO 4
`define APCR_ABE_LOCKOUT 3
`define APCR_ABE_EA_PARK 1
`define APCR_ABE_ANA_ON 0
`define APCR_MODE_ROLE_HI 7
`define APCR_MODE_ROLE_LO 6
`define APCR_MODE_FB 5
`define APCR_MODE_SEMI 3

// ----------------------------------------
// role codes and test selects
// ----------------------------------------
`define APCR_ROLE_ALONE 2'b00
`define APCR_ROLE_MASTER 2'b01
`define APCR_ROLE_SLAVE 2'b10
`define APCR_ROLE_SEMI 2'b11
`define APCR_DIGITAL_TEST_SELECT_W 3
`define APCR_DIGITAL_TEST_SELECT_SRCS 7

`endif

// >>> hdl/apcr_test_mux.v
// digital test source selector feeding the debug pin
// assumes sources are synchronised to pclk already
`timescale 1ns/1ps
`include "apcr_regs.vh"
module apcr_test_mux #(
  parameter NSRC = `APCR_DIGITAL_TEST_SELECT_SRCS
) (
  input wire pclk,
  input wire presetn,
  input wire [NSRC-1:0] src,
  input wire [`APCR_DIGITAL_TEST_SELECT_W-1:0] sel,
  output reg out_r
);
  // ----------------------------------------
  // one-hot decode per source
  // ----------------------------------------
  wire [NSRC-1:0] hit;
  genvar i;
  generate
    for (i = 0; i < NSRC; i = i + 1) begin : g_src
      assign hit[i] = (sel == i[`APCR_DIGITAL_TEST_SELECT_W-1:0]) & src[i];
    end
  endgenerate

  // registered so the pin sees no decode glitch; unused code gives low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= |hit;
    end
  end
endmodule

// >>> hdl/apcr_steer_pwm.v
// open-loop steering pwm generator
// assumes period and duty come from timer registers on the same clock
`timescale 1ns/1ps
module apcr_steer_pwm #(
  parameter W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [W-1:0] period,
  input wire [W-1:0] duty,
  output reg pwm_r
);
  reg [W-1:0] cnt_r;
  wire [W-1:0] cnt_nxt;

  // counter wraps at the period value, width kept exact
  assign cnt_nxt = (cnt_r >= period) ? {W{1'b0}} : cnt_r + {{(W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // period and duty comparison
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {W{1'b0}};
      pwm_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= {W{1'b0}};
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pwm_r <= (cnt_nxt < duty);
    end
  end
endmodule

// >>> hdl/apcr_top.v
// analog peripheral control register bank with apb slave
// assumes one pclk domain; analog status inputs arrive asynchronously
`timescale 1ns/1ps
`include "apcr_regs.vh"
module apcr_top #(
  parameter TW = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire [TW-1:0] timer_two_period,
  input wire [TW-1:0] timer_one_low_byte,
  input wire ov_protect_active,
  input wire loop_primary_pwm,
  input wire loop_secondary_pwm,
  input wire desaturation_flag,
  input wire pwm_after_mono,
  input wire osc_pwm,
  input wire timer_two_match,
  input wire ov_comparator,
  input wire switching_frequency_tap,
  input wire secondary_pulse_oneshot,
  input wire sync_clock_in_pad,
  input wire sync_gpio_out,
  input wire ref_gpio_out,
  output reg [7:0] secondary_reference_dac,
  output reg primary_gate_drive,
  output reg secondary_gate_drive,
  output reg primary_deadtime_skip,
  output reg secondary_deadtime_skip,
  output reg sense_pullup_on,
  output reg driver_lockout_level,
  output reg error_amp_park,
  output reg analog_test_to_adc,
  output reg analog_test_to_pin,
  output reg debug_out_is_digital,
  output wire debug_output_pin,
  output reg reference_output_is_dac,
  output reg reference_output_pin,
  output reg sync_pin,
  output reg sync_pin_oe,
  output reg sync_clock_input,
  output reg feedback_path_select
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] ref2_r;
  reg [7:0] pe1_r;
  reg [7:0] abe_r;
  reg [7:0] mode_r;

  wire wr_en;
  wire [3:0] addr_lo;
  assign addr_lo = paddr[3:0];
  // a write takes effect only in the access phase with lane 0 enabled
  assign wr_en = psel & penable & pwrite & pstrb[0];
  // zero-wait slave; unmapped addresses answer with an error
  wire mapped;
  assign mapped = (paddr[11:4] == 8'h00) & (addr_lo[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref2_r <= `APCR_RESET_VAL;
      pe1_r <= `APCR_RESET_VAL;
      abe_r <= `APCR_RESET_VAL;
      mode_r <= `APCR_RESET_VAL;
    end else if (wr_en && mapped) begin
      case (addr_lo)
        `APCR_ADDR_REF2: ref2_r <= pwdata[7:0] & `APCR_MASK_REF2;
        `APCR_ADDR_PE1: pe1_r <= pwdata[7:0] & `APCR_MASK_PE1;
        `APCR_ADDR_ABE: abe_r <= pwdata[7:0] & `APCR_MASK_ABE;
        `APCR_ADDR_MODE: mode_r <= pwdata[7:0] & `APCR_MASK_MODE;
        default: ref2_r <= ref2_r;
      endcase
    end
  end

  // read mux; reserved bits are masked at write, so they read zero
  always @* begin
    prdata = 32'h0000_0000;
    case (addr_lo)
      `APCR_ADDR_REF2: prdata = {24'h000000, ref2_r};
      `APCR_ADDR_PE1: prdata = {24'h000000, pe1_r};
      `APCR_ADDR_ABE: prdata = {24'h000000, abe_r};
      `APCR_ADDR_MODE: prdata = {24'h000000, mode_r};
      default: prdata = 32'h0000_0000;
    endcase
    if (!mapped) begin
      prdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // input synchronisers for analog-side status
  // ----------------------------------------
  localparam NS = 11;
  wire [NS-1:0] raw_in;
  reg [NS-1:0] meta_r;
  reg [NS-1:0] sync_r;
  assign raw_in = {sync_clock_in_pad, loop_secondary_pwm, loop_primary_pwm,
                   ov_protect_active, secondary_pulse_oneshot,
                   switching_frequency_tap, ov_comparator, timer_two_match,
                   osc_pwm, pwm_after_mono, desaturation_flag};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {NS{1'b0}};
      sync_r <= {NS{1'b0}};
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end
  wire s_sync_clock_input;
  wire s_ss_pwm;
  wire s_ps_pwm;
  wire s_ovp;
  assign s_sync_clock_input = sync_r[10];
  assign s_ss_pwm = sync_r[9];
  assign s_ps_pwm = sync_r[8];
  assign s_ovp = sync_r[7];

  // ----------------------------------------
  // steering pwm and test mux
  // ----------------------------------------
  wire p_steer;
  wire s_steer;
  wire steer_pwm;
  // primary steering dominates; secondary is ignored while both set
  assign p_steer = pe1_r[`APCR_PE1_PSTEER];
  assign s_steer = pe1_r[`APCR_PE1_SSTEER] & ~p_steer;

  apcr_steer_pwm #(
    .W(TW)
  ) u_steer (
    .pclk(pclk),
    .presetn(presetn),
    .run(p_steer | s_steer),
    .period(timer_two_period),
    .duty(timer_one_low_byte),
    .pwm_r(steer_pwm)
  );

  wire dig_test;
  apcr_test_mux #(
    .NSRC(`APCR_DIGITAL_TEST_SELECT_SRCS)
  ) u_mux (
    .pclk(pclk),
    .presetn(presetn),
    .src(sync_r[6:0]),
    .sel(abe_r[`APCR_ABE_DIGITAL_TEST_SELECT_HI:`APCR_ABE_DIGITAL_TEST_SELECT_LO]),
    .out_r(dig_test)
  );

  // debug pin carries digital test only when the digital path owns it
  assign debug_output_pin = debug_out_is_digital & dig_test;

  // ----------------------------------------
  // decoded controls, one edge after the write
  // ----------------------------------------
  reg [1:0] role;
  always @* begin
    role = mode_r[`APCR_MODE_ROLE_HI:`APCR_MODE_ROLE_LO];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_reference_dac <= 8'h00;
      primary_gate_drive <= 1'b0;
      secondary_gate_drive <= 1'b0;
      primary_deadtime_skip <= 1'b0;
      secondary_deadtime_skip <= 1'b0;
      sense_pullup_on <= 1'b0;
      driver_lockout_level <= 1'b0;
      error_amp_park <= 1'b0;
      analog_test_to_adc <= 1'b0;
      analog_test_to_pin <= 1'b0;
      debug_out_is_digital <= 1'b0;
      reference_output_is_dac <= 1'b0;
      reference_output_pin <= 1'b0;
      sync_pin <= 1'b0;
      sync_pin_oe <= 1'b0;
      sync_clock_input <= 1'b0;
      feedback_path_select <= 1'b0;
    end else begin
      // ground-referenced code straight to the dac, no pedestal added
      secondary_reference_dac <= ref2_r;
      // drive gated by enable; steering replaces the loop pwm
      if (!pe1_r[`APCR_PE1_PRIMARY_GATE_DRIVE_ON]) begin
        primary_gate_drive <= 1'b0;
      end else if (p_steer) begin
        primary_gate_drive <= steer_pwm;
      end else if (s_steer) begin
        primary_gate_drive <= 1'b0;
      end else begin
        primary_gate_drive <= s_ps_pwm;
      end
      if (!pe1_r[`APCR_PE1_SECONDARY_GATE_DRIVE_ON]) begin
        secondary_gate_drive <= 1'b0;
      end else if (p_steer) begin
        secondary_gate_drive <= 1'b0;
      end else if (s_steer) begin
        // pulses only while overvoltage protection is active
        secondary_gate_drive <= steer_pwm & s_ovp;
      end else begin
        secondary_gate_drive <= s_ss_pwm;
      end
      // dead time itself is analog; code selects 16 ns steps elsewhere
      primary_deadtime_skip <= pe1_r[`APCR_PE1_PSKIP];
      secondary_deadtime_skip <= pe1_r[`APCR_PE1_SSKIP];
      sense_pullup_on <= pe1_r[`APCR_PE1_PULLUP];
      driver_lockout_level <= abe_r[`APCR_ABE_LOCKOUT];
      error_amp_park <= abe_r[`APCR_ABE_EA_PARK];
      debug_out_is_digital <= abe_r[`APCR_ABE_DIG_ON];
      analog_test_to_pin <= abe_r[`APCR_ABE_ANA_ON] & ~abe_r[`APCR_ABE_DIG_ON];
      analog_test_to_adc <= abe_r[`APCR_ABE_ANA_ON] & ~abe_r[`APCR_ABE_DIG_ON];
      feedback_path_select <= mode_r[`APCR_MODE_FB];
      // pin routing by role
      case (role)
        `APCR_ROLE_MASTER: begin
          reference_output_is_dac <= 1'b1;
          reference_output_pin <= 1'b0;
          sync_pin <= steer_pwm | s_ps_pwm;
          sync_pin_oe <= 1'b1;
          sync_clock_input <= 1'b0;
        end
        `APCR_ROLE_SLAVE: begin
          reference_output_is_dac <= 1'b0;
          reference_output_pin <= ref_gpio_out;
          sync_pin <= 1'b0;
          sync_pin_oe <= 1'b0;
          sync_clock_input <= s_sync_clock_input;
        end
        `APCR_ROLE_SEMI: begin
          if (mode_r[`APCR_MODE_SEMI]) begin
            reference_output_is_dac <= 1'b0;
            reference_output_pin <= ref_gpio_out;
            sync_pin <= steer_pwm | s_ps_pwm;
            sync_pin_oe <= 1'b1;
          end else begin
            reference_output_is_dac <= 1'b1;
            reference_output_pin <= 1'b0;
            sync_pin <= sync_gpio_out;
            sync_pin_oe <= 1'b1;
          end
          sync_clock_input <= 1'b0;
        end
        default: begin
          // stand-alone: nothing of the dac or sync reaches the pins
          reference_output_is_dac <= 1'b0;
          reference_output_pin <= ref_gpio_out;
          sync_pin <= sync_gpio_out;
          sync_pin_oe <= 1'b0;
          sync_clock_input <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> sim/apcr_sva.sv
// checker for the analog control bank: apb answer and decoded controls
// assumes it is bound to apcr_top and sees only its ports
`timescale 1ns/1ps
module apcr_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire [7:0] secondary_reference_dac,
  input wire primary_gate_drive,
  input wire secondary_gate_drive,
  input wire primary_deadtime_skip,
  input wire secondary_deadtime_skip,
  input wire driver_lockout_level,
  input wire analog_test_to_adc,
  input wire analog_test_to_pin,
  input wire debug_out_is_digital,
  input wire debug_output_pin,
  input wire reference_output_is_dac,
  input wire sync_pin_oe
);
  // ----------------------------------------
  // shadow of what software wrote
  // ----------------------------------------
  reg [7:0] pe1_s;
  reg [7:0] abe_s;
  reg [7:0] mode_s;
  wire acc = psel && penable && pready;
  wire bad = (paddr[11:4] != 8'h00) || (paddr[1:0] != 2'h0);
  wire wr = acc && pwrite && pstrb[0] && !bad;
  // reserved bits kept as written; no assertion looks at them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe1_s <= 8'h00;
      abe_s <= 8'h00;
      mode_s <= 8'h00;
    end else if (wr) begin
      if (paddr[3:2] == 2'h1) pe1_s <= pwdata[7:0];
      if (paddr[3:2] == 2'h2) abe_s <= pwdata[7:0];
      if (paddr[3:2] == 2'h3) mode_s <= pwdata[7:0];
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel |-> pready) else $error("apb wait state");
  a_bad_addr: assert property (acc |-> pslverr == bad) else $error("pslverr wrong");
  a_dac_code: assert property (wr && paddr[3:2] == 2'h0 |=> ##1
    secondary_reference_dac == $past(pwdata[7:0], 2)) else $error("dac code not applied");
  a_primary_gate_drive_gated: assert property (!$past(pe1_s[7]) |-> !primary_gate_drive)
    else $error("primary drive while disabled");
  a_secondary_gate_drive_gated: assert property (!$past(pe1_s[6]) |-> !secondary_gate_drive)
    else $error("secondary drive while disabled");
  a_primary_wins: assert property ($past(pe1_s[1]) |-> !secondary_gate_drive)
    else $error("secondary steered under primary steering");
  a_skip_follow: assert property (primary_deadtime_skip == $past(pe1_s[5]) &&
    secondary_deadtime_skip == $past(pe1_s[4])) else $error("dead time skip wrong");
  a_digital_wins: assert property ($past(abe_s[7]) |-> debug_out_is_digital &&
    !analog_test_to_pin && !analog_test_to_adc) else $error("digital test not first");
  a_analog_adc: assert property ($past(abe_s[0] && !abe_s[7]) |->
    analog_test_to_adc && analog_test_to_pin) else $error("analog test not routed");
  a_lockout_sel: assert property (driver_lockout_level == $past(abe_s[3]))
    else $error("lockout level wrong");
  a_code7_low: assert property ($past(abe_s[6:4], 1) == 3'h7 &&
    $past(abe_s[6:4], 2) == 3'h7 |-> !debug_output_pin) else $error("code 7 not low");
  a_alone_quiet: assert property ($past(mode_s[7:6]) == 2'b00 |->
    !reference_output_is_dac && !sync_pin_oe) else $error("stand-alone routes pins");
  a_master_route: assert property ($past(mode_s[7:6]) == 2'b01 |->
    reference_output_is_dac && sync_pin_oe) else $error("master routing wrong");
  a_semi_clock: assert property ($past(mode_s[7:6] == 2'b11 && mode_s[3]) |->
    !reference_output_is_dac && sync_pin_oe) else $error("semi-master option wrong");
  c_err: cover property (acc && bad);
  c_steer: cover property ($past(pe1_s[1]) && primary_gate_drive);
  c_semi: cover property ($past(mode_s[7:6]) == 2'b11);
endmodule

bind apcr_top apcr_sva i_apcr_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .pready, .pslverr, .secondary_reference_dac, .primary_gate_drive,
  .secondary_gate_drive, .primary_deadtime_skip, .secondary_deadtime_skip,
  .driver_lockout_level, .analog_test_to_adc, .analog_test_to_pin, .debug_out_is_digital,
  .debug_output_pin, .reference_output_is_dac, .sync_pin_oe);

// >>> sim/apcr_top_tb.sv
// self-checking bench for the analog control bank
// assumes apcr_top with its header on the include path; apb master at 40 mhz
`timescale 1ns/1ps
`include "apcr_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module apcr_top_tb;
  reg pclk, presetn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata, rdat, seed;
  reg [3:0] pstrb;
  reg [12:0] ain;
  reg [7:0] per, duty;
  reg rerr;
  wire pready, pslverr, primary_gate_drive, secondary_gate_drive, primary_deadtime_skip;
  wire secondary_deadtime_skip, sense_pullup_on, driver_lockout_level, error_amp_park;
  wire analog_test_to_adc, analog_test_to_pin, debug_out_is_digital, debug_output_pin;
  wire reference_output_is_dac, sync_pin_oe, sync_clock_input, feedback_path_select;
  wire reference_output_pin, sync_pin;
  wire [31:0] prdata;
  wire [7:0] secondary_reference_dac;
  integer err_count, n_checks, i, j, np, ns;
  // ain: sources 6:0, ov 7, loop pwms 9:8, sync pad 10, gpio data 12:11
  apcr_top i_apcr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .prdata, .timer_two_period(per), .timer_one_low_byte(duty),
    .ov_protect_active(ain[7]), .loop_primary_pwm(ain[8]), .loop_secondary_pwm(ain[9]),
    .desaturation_flag(ain[0]), .pwm_after_mono(ain[1]), .osc_pwm(ain[2]),
    .timer_two_match(ain[3]), .ov_comparator(ain[4]), .switching_frequency_tap(ain[5]),
    .secondary_pulse_oneshot(ain[6]), .sync_clock_in_pad(ain[10]), .sync_gpio_out(ain[11]),
    .ref_gpio_out(ain[12]), .secondary_reference_dac, .primary_gate_drive,
    .secondary_gate_drive, .primary_deadtime_skip, .secondary_deadtime_skip,
    .sense_pullup_on, .driver_lockout_level, .error_amp_park, .analog_test_to_adc,
    .analog_test_to_pin, .debug_out_is_digital, .debug_output_pin, .reference_output_is_dac,
    .reference_output_pin, .sync_pin, .sync_pin_oe, .sync_clock_input,
    .feedback_path_select);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  function [7:0] mk(input [1:0] k);
    mk = k == 0 ? `APCR_MASK_REF2 : k == 1 ? `APCR_MASK_PE1 : k == 2 ? `APCR_MASK_ABE
      : `APCR_MASK_MODE;
  endfunction
  // one transfer; holds until pready is seen, then releases for one cycle
  task apb(input [11:0] a, input w, input [31:0] d, input [3:0] s);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count assumed; only the watchdog ends a hung access
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // waits for the synchroniser and the decode, then drive ratio over four periods
  task steer(input [7:0] v, input ov);
    begin
      ain[7] <= ov;
      // desaturation output gate lies outside this bank; software clears it
      apb(12'h004, 1'b1, {24'h0, v}, 4'hf);
      repeat (8) @(posedge pclk);
      np = 0;
      ns = 0;
      repeat (4 * (per + 1)) begin
        @(posedge pclk);
        np = np + primary_gate_drive;
        ns = ns + secondary_gate_drive;
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, ain, per, duty} = 0;
    err_count = 0;
    n_checks = 0;
    seed = 32'h9a05d75d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(i * 4, 1'b0, 0, 4'hf);
      `CHK(rdat, 32'h0)
    end
    $display("reset values done");
    for (i = 0; i < 32; i++) begin
      seed = xs(seed);
      ain <= seed[30:18];
      apb(seed[1:0] * 4, 1'b1, seed, 4'hf);
      @(posedge pclk);
      case (seed[1:0])
        0: `CHK(secondary_reference_dac, seed[7:0])
        1: `CHK({primary_deadtime_skip, secondary_deadtime_skip, sense_pullup_on},
          {seed[5:4], seed[2]})
        2: `CHK({driver_lockout_level, error_amp_park}, {seed[3], seed[1]})
        3: `CHK(feedback_path_select, seed[5])
      endcase
      apb(seed[1:0] * 4, 1'b0, 0, 4'hf);
      `CHK(rdat, {24'h0, seed[7:0] & mk(seed[1:0])})
    end
    $display("random access done");
    apb(12'h000, 1'b1, 32'h33, 4'hf);
    apb(12'h010, 1'b1, 32'hff, 4'hf);
    `CHK(rerr, 1'b1)
    apb(12'h001, 1'b1, 32'hff, 4'hf);
    `CHK(rerr, 1'b1)
    apb(12'h000, 1'b1, 32'h5a, 4'he);
    apb(12'h000, 1'b0, 0, 4'hf);
    `CHK(rdat, 32'h33)
    $display("refused access done");
    for (i = 0; i < 8; i++) begin
      apb(12'h008, 1'b1, 32'h81 | (i << 4), 4'hf);
      ain[6:0] <= 7'h01 << i;
      repeat (6) @(posedge pclk);
      `CHK(debug_output_pin, i < 7)
      ain[6:0] <= ~(7'h01 << i);
      repeat (6) @(posedge pclk);
      `CHK({debug_output_pin, debug_out_is_digital, analog_test_to_adc}, 3'b010)
    end
    apb(12'h008, 1'b1, 32'h01, 4'hf);
    @(posedge pclk);
    `CHK({debug_out_is_digital, analog_test_to_adc, analog_test_to_pin}, 3'b011)
    $display("test routing done");
    for (j = 0; j < 5; j++) begin
      // gpio data high, loop pwm low: routed gpio shows 1, sync clock shows 0
      ain[12:10] <= 3'b111;
      ain[8] <= 1'b0;
      apb(12'h00c, 1'b1, j == 0 ? 0 : j == 1 ? 32'h40 : j == 2 ? 32'h80 : j == 3 ? 32'hc8
        : 32'hc0, 4'hf);
      repeat (4) @(posedge pclk);
      `CHK(reference_output_is_dac, j == 1 || j == 4)
      if (j < 4) `CHK(sync_pin_oe, j == 1 || j == 3)
      if (j == 2) `CHK(sync_clock_input, 1'b1)
      `CHK(reference_output_pin, j == 0 || j == 2 || j == 3)
      `CHK(sync_pin, j == 0 || j == 4)
    end
    $display("role select done");
    // mid-run reset must clear every register and fall back to stand-alone
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(i * 4, 1'b0, 0, 4'hf);
      `CHK(rdat, 32'h0)
    end
    `CHK({reference_output_is_dac, sync_pin_oe, primary_gate_drive}, 3'b000)
    $display("mid-run reset done");
    seed = xs(seed);
    per <= 8'd4 + seed[2:0];
    duty <= 8'd1 + seed[10:3] % (8'd4 + seed[2:0]);
    ain <= 0;
    steer(8'h82, 1'b0);
    `CHK({np, ns}, {4 * duty, 32'd0})
    steer(8'h02, 1'b1);
    `CHK(np, 0)
    steer(8'h41, 1'b1);
    `CHK({np, ns}, {32'd0, 4 * duty})
    steer(8'h41, 1'b0);
    `CHK(ns, 0)
    steer(8'hc3, 1'b1);
    `CHK({np, ns}, {4 * duty, 32'd0})
    $display("steering done");
    print_verdict;
  end
endmodule
